// ===== shared/rpc_regs_map.vh
`ifndef RPC_REGS_MAP_VH
`define RPC_REGS_MAP_VH

// Register addresses on the 3-bit host port
`define RPC_ADDR_W 3
`define RPC_OFS_PTR_HIGH 3'h2
`define RPC_OFS_PTR_LOW 3'h3
`define RPC_OFS_RAM_DATA 3'h4
`define RPC_OFS_CONTROL 3'h6
`define RPC_OFS_SHARED 3'h7

// Pointer high fields
`define RPC_PH_READ 7
`define RPC_PH_AUTO 6
`define RPC_PH_UP_MSB 2
`define RPC_PH_UP_LSB 0

// Device control fields
`define RPC_DC_SWRST 7
`define RPC_DC_CHAIN 6
`define RPC_DC_TXPERMIT 5
`define RPC_DC_TO_HI 4
`define RPC_DC_TO_LO 3
`define RPC_DC_DIRECT 2
`define RPC_DC_SEL_MSB 1
`define RPC_DC_SEL_LSB 0

// Reset values
`define RPC_CTRL_RST 8'h00
`define RPC_PTR_RST 11'h000
`define RPC_BYTE_ZERO 8'h00
`define RPC_PTR_ONE 11'h001

// Timeout codes
`define RPC_TO_00 2'h0
`define RPC_TO_01 2'h1
`define RPC_TO_10 2'h2
`define RPC_TO_11 2'h3

// Clock rate and printed times (tenths of us, and ms)
`define RPC_CLK_MHZ 250
`define RPC_RESP_T00_DUS 11936
`define RPC_RESP_T01_DUS 5968
`define RPC_RESP_T10_DUS 2984
`define RPC_RESP_T11_DUS 747
`define RPC_IDLE_T00_DUS 13120
`define RPC_IDLE_T01_DUS 6560
`define RPC_IDLE_T10_DUS 3280
`define RPC_IDLE_T11_DUS 820
`define RPC_RECON_LONG_MS 1680
`define RPC_RECON_SHORT_MS 840
`define RPC_DUS_PER_US 10
`define RPC_KHZ_PER_MHZ 1000

// Cycle counts derived from the times and the clock rate
`define RPC_DUS2CYC(t) ((t) * `RPC_CLK_MHZ / `RPC_DUS_PER_US)
`define RPC_MS2CYC(t) ((t) * `RPC_CLK_MHZ * `RPC_KHZ_PER_MHZ)
`define RPC_CNT_W 29

`endif

// ===== core/rpc_timeout_sel.v
`timescale 1ns/1ps
`include "rpc_regs_map.vh"

module rpc_timeout_sel #(
  parameter CNT_W = `RPC_CNT_W,
  parameter [CNT_W-1:0] RESP_00 = `RPC_DUS2CYC(`RPC_RESP_T00_DUS),
  parameter [CNT_W-1:0] RESP_01 = `RPC_DUS2CYC(`RPC_RESP_T01_DUS),
  parameter [CNT_W-1:0] RESP_10 = `RPC_DUS2CYC(`RPC_RESP_T10_DUS),
  parameter [CNT_W-1:0] RESP_11 = `RPC_DUS2CYC(`RPC_RESP_T11_DUS),
  parameter [CNT_W-1:0] IDLE_00 = `RPC_DUS2CYC(`RPC_IDLE_T00_DUS),
  parameter [CNT_W-1:0] IDLE_01 = `RPC_DUS2CYC(`RPC_IDLE_T01_DUS),
  parameter [CNT_W-1:0] IDLE_10 = `RPC_DUS2CYC(`RPC_IDLE_T10_DUS),
  parameter [CNT_W-1:0] IDLE_11 = `RPC_DUS2CYC(`RPC_IDLE_T11_DUS),
  parameter [CNT_W-1:0] RECON_LONG = `RPC_MS2CYC(`RPC_RECON_LONG_MS),
  parameter [CNT_W-1:0] RECON_SHORT = `RPC_MS2CYC(`RPC_RECON_SHORT_MS)
) (
  input wire clk,
  input wire rst_b,
  input wire [1:0] code,
  output reg [CNT_W-1:0] resp_cyc_r,
  output reg [CNT_W-1:0] idle_cyc_r,
  output reg [CNT_W-1:0] recon_cyc_r
);

  reg [CNT_W-1:0] resp_nxt;
  reg [CNT_W-1:0] idle_nxt;
  reg [CNT_W-1:0] recon_nxt;

  always @* begin
    resp_nxt = RESP_00;
    idle_nxt = IDLE_00;
    recon_nxt = RECON_LONG;
    case (code)
      `RPC_TO_00: begin
        resp_nxt = RESP_00; // R12
        idle_nxt = IDLE_00;
        recon_nxt = RECON_LONG;
      end
      `RPC_TO_01: begin
        resp_nxt = RESP_01; // R13
        idle_nxt = IDLE_01;
        recon_nxt = RECON_LONG;
      end
      `RPC_TO_10: begin
        resp_nxt = RESP_10; // R13
        idle_nxt = IDLE_10;
        recon_nxt = RECON_LONG;
      end
      `RPC_TO_11: begin
        resp_nxt = RESP_11; // R12
        idle_nxt = IDLE_11;
        recon_nxt = RECON_SHORT;
      end
      default: begin
        resp_nxt = RESP_00;
        idle_nxt = IDLE_00;
        recon_nxt = RECON_LONG;
      end
    endcase
  end

  // Reset value matches code 00, the control register reset value
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      resp_cyc_r <= RESP_00;
      idle_cyc_r <= IDLE_00;
      recon_cyc_r <= RECON_LONG;
    end else begin
      resp_cyc_r <= resp_nxt;
      idle_cyc_r <= idle_nxt;
      recon_cyc_r <= recon_nxt;
    end
  end

endmodule

// ===== core/rpc_regs.v
// Overview of operation
// R01: Pointer high bit 7 one means next RAM data access reads, zero writes.
// R02: Pointer high bit 6 set advances the pointer after each data access.
// R03: Pointer high bits 2-0 give RAM address 10-8; bits 5-3 unused.
// R04: Pointer low bits 7-0 give RAM address 7-0.
// R05: Advance treats pointer as 11 bits, carrying and wrapping to zero.
// R06: Writing one to control bit 7 enters software reset.
// R07: Software reset clears status, next id, diagnostics; not control.
// R08: Software reset holds while bit stays one; host writes zero to leave.
// R09: Control bit 6 high selects command chaining, low legacy behaviour.
// R10: Control bit 5 low holds line pulses and driver enable inactive; here pulse B still passes when bit 2 selects direct mode.
// R11: Transmit permit resets to zero so the line stays silent.
// R12: Timeout code 00 and 11 select response, idle, reconfiguration times.
// R13: Timeout codes 01 and 10 halve and quarter times, long reconfig.
// R14: Host programs the same timeout code in every node.
// R15: Control bit 2 selects direct media signalling on line outputs.
// R16: Control bits 1,0 pick which register appears at address 07.
`timescale 1ns/1ps
`include "rpc_regs_map.vh"

module rpc_regs #(
  parameter CNT_W = `RPC_CNT_W,
  parameter [CNT_W-1:0] RESP_00 = `RPC_DUS2CYC(`RPC_RESP_T00_DUS),
  parameter [CNT_W-1:0] RESP_01 = `RPC_DUS2CYC(`RPC_RESP_T01_DUS),
  parameter [CNT_W-1:0] RESP_10 = `RPC_DUS2CYC(`RPC_RESP_T10_DUS),
  parameter [CNT_W-1:0] RESP_11 = `RPC_DUS2CYC(`RPC_RESP_T11_DUS),
  parameter [CNT_W-1:0] IDLE_00 = `RPC_DUS2CYC(`RPC_IDLE_T00_DUS),
  parameter [CNT_W-1:0] IDLE_01 = `RPC_DUS2CYC(`RPC_IDLE_T01_DUS),
  parameter [CNT_W-1:0] IDLE_10 = `RPC_DUS2CYC(`RPC_IDLE_T10_DUS),
  parameter [CNT_W-1:0] IDLE_11 = `RPC_DUS2CYC(`RPC_IDLE_T11_DUS),
  parameter [CNT_W-1:0] RECON_LONG = `RPC_MS2CYC(`RPC_RECON_LONG_MS),
  parameter [CNT_W-1:0] RECON_SHORT = `RPC_MS2CYC(`RPC_RECON_SHORT_MS)
) (
  input wire SYS_CLK,
  input wire RST_B,
  input wire [`RPC_ADDR_W-1:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [7:0] RDATA,
  input wire [7:0] RAM_RDATA,
  input wire [7:0] SHARED_RDATA,
  input wire PULSE_A_REQ,
  input wire PULSE_B_REQ,
  input wire DRIVER_EN_REQ,
  output reg [10:0] RAM_ADDR,
  output reg RAM_RD_STB,
  output reg RAM_WR_STB,
  output reg [7:0] HOST_WDATA,
  output reg SHARED_WR_STB,
  output reg [1:0] SHARED_REG_SEL,
  output reg SOFT_RESET,
  output reg CHAINED_COMMAND_ENABLE,
  output reg DIRECT_MEDIA_SIGNALLING,
  output reg LINE_PULSE_A_N,
  output reg LINE_PULSE_B_N,
  output reg LINE_DRIVER_ENABLE_N,
  output wire [CNT_W-1:0] RESP_TIMEOUT_CYC,
  output wire [CNT_W-1:0] IDLE_TIMEOUT_CYC,
  output wire [CNT_W-1:0] RECON_TIMEOUT_CYC
);

  ////////////////////////////////////////////////////////////////////////
  // Register state

  reg next_access_is_read_r;
  reg pointer_auto_advance_r;
  reg [10:0] ptr_r;
  reg [10:0] ptr_nxt;
  reg [7:0] ctrl_r;
  reg [7:0] ctrl_nxt;
  reg [7:0] rdata_nxt;

  wire sel_ph = (ADDR == `RPC_OFS_PTR_HIGH);
  wire sel_pl = (ADDR == `RPC_OFS_PTR_LOW);
  wire sel_data = (ADDR == `RPC_OFS_RAM_DATA);
  wire sel_ctrl = (ADDR == `RPC_OFS_CONTROL);
  wire sel_sh = (ADDR == `RPC_OFS_SHARED);

  // A data strobe against the programmed direction is dropped, so a
  // stray write can never corrupt RAM while a read burst is set up.
  wire ram_rd = RD && sel_data && next_access_is_read_r; // R01
  wire ram_wr = WR && sel_data && !next_access_is_read_r; // R01
  wire ram_acc = ram_rd || ram_wr;

  wire tx_ok = ctrl_r[`RPC_DC_TXPERMIT];
  wire direct = ctrl_r[`RPC_DC_DIRECT];

  ////////////////////////////////////////////////////////////////////////
  // Pointer and control next state

  always @* begin
    ptr_nxt = ptr_r;
    if (WR && sel_ph) begin
      ptr_nxt[10:8] = WDATA[`RPC_PH_UP_MSB:`RPC_PH_UP_LSB]; // R03
    end else if (WR && sel_pl) begin
      ptr_nxt[7:0] = WDATA; // R04
    end else if (ram_acc && pointer_auto_advance_r) begin // R02
      ptr_nxt = ptr_r + `RPC_PTR_ONE; // R05
    end
  end

  always @* begin
    ctrl_nxt = ctrl_r;
    if (WR && sel_ctrl) begin
      ctrl_nxt = WDATA; // R06 R08
    end
  end

  always @* begin
    rdata_nxt = `RPC_BYTE_ZERO;
    if (RD) begin
      case (ADDR)
        `RPC_OFS_PTR_HIGH: begin
          rdata_nxt[`RPC_PH_READ] = next_access_is_read_r;
          rdata_nxt[`RPC_PH_AUTO] = pointer_auto_advance_r;
          rdata_nxt[`RPC_PH_UP_MSB:`RPC_PH_UP_LSB] = ptr_r[10:8];
        end
        `RPC_OFS_PTR_LOW: begin
          rdata_nxt = ptr_r[7:0];
        end
        `RPC_OFS_RAM_DATA: begin
          if (next_access_is_read_r) begin
            rdata_nxt = RAM_RDATA;
          end
        end
        `RPC_OFS_CONTROL: begin
          rdata_nxt = ctrl_r;
        end
        `RPC_OFS_SHARED: begin
          rdata_nxt = SHARED_RDATA; // R16
        end
        default: begin
          rdata_nxt = `RPC_BYTE_ZERO;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers. Only RST_B clears them; software reset leaves them alone.

  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      next_access_is_read_r <= 1'b0;
      pointer_auto_advance_r <= 1'b0;
      ptr_r <= `RPC_PTR_RST;
      ctrl_r <= `RPC_CTRL_RST; // R11
      RDATA <= `RPC_BYTE_ZERO;
    end else begin
      if (WR && sel_ph) begin
        next_access_is_read_r <= WDATA[`RPC_PH_READ]; // R01
        pointer_auto_advance_r <= WDATA[`RPC_PH_AUTO]; // R02
      end
      ptr_r <= ptr_nxt;
      ctrl_r <= ctrl_nxt; // R07
      RDATA <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs to RAM, shared register bank and protocol engine

  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      RAM_ADDR <= `RPC_PTR_RST;
      RAM_RD_STB <= 1'b0;
      RAM_WR_STB <= 1'b0;
      HOST_WDATA <= `RPC_BYTE_ZERO;
      SHARED_WR_STB <= 1'b0;
      SHARED_REG_SEL <= 2'h0;
      SOFT_RESET <= 1'b0;
      CHAINED_COMMAND_ENABLE <= 1'b0;
      DIRECT_MEDIA_SIGNALLING <= 1'b0;
    end else begin
      // A write strobe needs the address before its advance; otherwise
      // follow the next pointer so back-to-back reads see fresh data
      RAM_ADDR <= ram_wr ? ptr_r : ptr_nxt; // R02 R03 R04
      RAM_RD_STB <= ram_rd;
      RAM_WR_STB <= ram_wr;
      HOST_WDATA <= WDATA;
      SHARED_WR_STB <= WR && sel_sh;
      SHARED_REG_SEL <= ctrl_nxt[`RPC_DC_SEL_MSB:`RPC_DC_SEL_LSB]; // R16
      // Level follows the bit; the engine clears status, next id, diagnostics
      SOFT_RESET <= ctrl_nxt[`RPC_DC_SWRST]; // R06 R07 R08
      CHAINED_COMMAND_ENABLE <= ctrl_nxt[`RPC_DC_CHAIN]; // R09
      DIRECT_MEDIA_SIGNALLING <= ctrl_nxt[`RPC_DC_DIRECT]; // R15
    end
  end

  // Line outputs are active low; high is the idle level
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      LINE_PULSE_A_N <= 1'b1;
      LINE_PULSE_B_N <= 1'b1;
      LINE_DRIVER_ENABLE_N <= 1'b1;
    end else begin
      LINE_PULSE_A_N <= !(PULSE_A_REQ && tx_ok); // R10
      // Second pulse is gated by the permit only outside direct mode
      LINE_PULSE_B_N <= !(PULSE_B_REQ && (tx_ok || direct)); // R10 R15
      LINE_DRIVER_ENABLE_N <= !(DRIVER_EN_REQ && tx_ok); // R10
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Timeout selection; every node must share the code for the timing
  // to agree across the network (R14)

  rpc_timeout_sel #(
    .CNT_W(CNT_W),
    .RESP_00(RESP_00),
    .RESP_01(RESP_01),
    .RESP_10(RESP_10),
    .RESP_11(RESP_11),
    .IDLE_00(IDLE_00),
    .IDLE_01(IDLE_01),
    .IDLE_10(IDLE_10),
    .IDLE_11(IDLE_11),
    .RECON_LONG(RECON_LONG),
    .RECON_SHORT(RECON_SHORT)
  ) u_timeout (
    .clk(SYS_CLK),
    .rst_b(RST_B),
    .code(ctrl_r[`RPC_DC_TO_HI:`RPC_DC_TO_LO]), // R12 R13
    .resp_cyc_r(RESP_TIMEOUT_CYC),
    .idle_cyc_r(IDLE_TIMEOUT_CYC),
    .recon_cyc_r(RECON_TIMEOUT_CYC)
  );

endmodule

// ===== test/rpc_ram_model.sv
`timescale 1ns/1ps

module rpc_ram_model (
  input wire clk,
  input wire [10:0] ram_addr,
  input wire wr_stb,
  input wire [7:0] wdata,
  output wire [7:0] rdata
);
  reg [7:0] mem [0:2047];
  integer i;
  // Each byte seeded from its low address byte, so a wrong low byte cannot pass
  initial begin
    for (i = 0; i < 2048; i = i + 1) begin
      mem[i] = i[7:0] ^ 8'h5A;
    end
  end
  assign rdata = mem[ram_addr];
  always @(posedge clk) begin
    if (wr_stb) begin
      mem[ram_addr] <= wdata;
    end
  end
endmodule

// ===== test/rpc_regs_monitor.sv
`timescale 1ns/1ps
`include "rpc_regs_map.vh"

module rpc_regs_monitor #(
  parameter CNT_W = 29,
  parameter [CNT_W-1:0] RECON_LONG = 99,
  parameter [CNT_W-1:0] RECON_SHORT = 50
) (
  input wire SYS_CLK,
  input wire RST_B,
  input wire [`RPC_ADDR_W-1:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR,
  input wire RD,
  input wire DRIVER_EN_REQ,
  input wire [10:0] RAM_ADDR,
  input wire RAM_RD_STB,
  input wire RAM_WR_STB,
  input wire SOFT_RESET,
  input wire LINE_PULSE_A_N,
  input wire LINE_DRIVER_ENABLE_N,
  input wire [CNT_W-1:0] RECON_TIMEOUT_CYC
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  wire ctl_wr = WR && ADDR == `RPC_OFS_CONTROL;
  reg permit_r;
  // Shadow of the permit bit, since the design does not export it
  always @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      permit_r <= 1'b0;
    end else if (ctl_wr) begin
      permit_r <= WDATA[`RPC_DC_TXPERMIT];
    end
  end
  sequence s_hi_rd;
    WR && ADDR == `RPC_OFS_PTR_HIGH && WDATA[7];
  endsequence
  sequence s_data_wr;
    WR && ADDR == `RPC_OFS_RAM_DATA;
  endsequence
  sequence s_data_rd;
    RD && ADDR == `RPC_OFS_RAM_DATA;
  endsequence
  sequence s_low_wr;
    WR && ADDR == `RPC_OFS_PTR_LOW ##1 !WR && !RD;
  endsequence
  AST_WR_DIR: assert property (s_hi_rd ##1 s_data_wr |=> !RAM_WR_STB)
    else $error("data write taken with read flag set");
  AST_NO_AUTO: assert property (s_hi_rd ##0 !WDATA[6] ##1 s_data_rd
    |=> RAM_RD_STB ##1 RAM_ADDR == $past(RAM_ADDR))
    else $error("pointer moved without auto advance");
  AST_PTR_LOW: assert property (s_low_wr |=>
    RAM_ADDR[7:0] == $past(WDATA, 2))
    else $error("low address byte wrong");
  AST_PTR_HIGH: assert property (WR && ADDR == `RPC_OFS_PTR_HIGH
    ##1 !WR && !RD |=> {5'h00, RAM_ADDR[10:8]} == ($past(WDATA, 2) & 8'h07))
    else $error("upper address bits wrong");
  AST_SWRST: assert property (ctl_wr |=> SOFT_RESET == $past(WDATA[7]))
    else $error("soft reset not following bit 7");
  AST_SWRST_HOLD: assert property (SOFT_RESET && !ctl_wr |=> SOFT_RESET)
    else $error("soft reset released without write");
  AST_LINE_OFF: assert property (!permit_r |=>
    LINE_DRIVER_ENABLE_N && LINE_PULSE_A_N)
    else $error("line active without permit");
  AST_LINE_ON: assert property (permit_r && DRIVER_EN_REQ |=>
    !LINE_DRIVER_ENABLE_N)
    else $error("driver enable not passed");
  AST_RECON: assert property (ctl_wr |-> ##2 RECON_TIMEOUT_CYC ==
    ((($past(WDATA, 2) & 8'h18) == 8'h18) ? RECON_SHORT : RECON_LONG))
    else $error("reconfiguration count wrong");
endmodule

bind rpc_regs rpc_regs_monitor #(.CNT_W(CNT_W), .RECON_LONG(RECON_LONG),
  .RECON_SHORT(RECON_SHORT)) u_mon (.SYS_CLK(SYS_CLK), .RST_B(RST_B),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .DRIVER_EN_REQ(DRIVER_EN_REQ), .RAM_ADDR(RAM_ADDR),
  .RAM_RD_STB(RAM_RD_STB), .RAM_WR_STB(RAM_WR_STB),
  .SOFT_RESET(SOFT_RESET), .LINE_PULSE_A_N(LINE_PULSE_A_N),
  .LINE_DRIVER_ENABLE_N(LINE_DRIVER_ENABLE_N),
  .RECON_TIMEOUT_CYC(RECON_TIMEOUT_CYC));

// ===== test/tb_rpc_regs.sv
`timescale 1ns/1ps
`include "rpc_regs_map.vh"

module tb_rpc_regs;
  reg SYS_CLK, RST_B, WR, RD, PULSE_A_REQ, PULSE_B_REQ, DRIVER_EN_REQ;
  reg [2:0] ADDR;
  reg [7:0] WDATA, SHARED_RDATA, rv, rv2;
  wire [7:0] RDATA, RAM_RDATA, HOST_WDATA;
  wire [10:0] RAM_ADDR;
  wire RAM_WR_STB, SOFT_RESET, CHAINED_COMMAND_ENABLE, DIRECT_MEDIA_SIGNALLING;
  wire LINE_PULSE_A_N, LINE_PULSE_B_N, LINE_DRIVER_ENABLE_N;
  wire SHARED_WR_STB;
  wire [1:0] SHARED_REG_SEL;
  wire [`RPC_CNT_W-1:0] RESP_TIMEOUT_CYC, IDLE_TIMEOUT_CYC;
  wire [`RPC_CNT_W-1:0] RECON_TIMEOUT_CYC;
  integer n_mismatch = 0, checks_done = 0, i;
  localparam [31:0] recon_long_cyc = `RPC_MS2CYC(`RPC_RECON_LONG_MS);
  localparam [31:0] recon_short_cyc = `RPC_MS2CYC(`RPC_RECON_SHORT_MS);
  // Default counts: they are only selected here, never counted down
  rpc_regs u_dut (.SYS_CLK(SYS_CLK),
    .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .RAM_RDATA(RAM_RDATA), .SHARED_RDATA(SHARED_RDATA),
    .PULSE_A_REQ(PULSE_A_REQ), .PULSE_B_REQ(PULSE_B_REQ),
    .DRIVER_EN_REQ(DRIVER_EN_REQ), .RAM_ADDR(RAM_ADDR), .RAM_RD_STB(),
    .RAM_WR_STB(RAM_WR_STB), .HOST_WDATA(HOST_WDATA),
    .SHARED_WR_STB(SHARED_WR_STB),
    .SHARED_REG_SEL(SHARED_REG_SEL), .SOFT_RESET(SOFT_RESET),
    .CHAINED_COMMAND_ENABLE(CHAINED_COMMAND_ENABLE),
    .DIRECT_MEDIA_SIGNALLING(DIRECT_MEDIA_SIGNALLING),
    .LINE_PULSE_A_N(LINE_PULSE_A_N), .LINE_PULSE_B_N(LINE_PULSE_B_N),
    .LINE_DRIVER_ENABLE_N(LINE_DRIVER_ENABLE_N),
    .RESP_TIMEOUT_CYC(RESP_TIMEOUT_CYC), .IDLE_TIMEOUT_CYC(IDLE_TIMEOUT_CYC),
    .RECON_TIMEOUT_CYC(RECON_TIMEOUT_CYC));
  rpc_ram_model u_ram (.clk(SYS_CLK), .ram_addr(RAM_ADDR),
    .wr_stb(RAM_WR_STB), .wdata(HOST_WDATA), .rdata(RAM_RDATA));
  ////////////////////////////////////////////////////////////////////////
  task chk(input [63:0] nm, input [31:0] seen, input [31:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("BAD %0s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  function [31:0] resp_exp(input integer c);
    case (c)
      0: resp_exp = `RPC_DUS2CYC(`RPC_RESP_T00_DUS);
      1: resp_exp = `RPC_DUS2CYC(`RPC_RESP_T01_DUS);
      2: resp_exp = `RPC_DUS2CYC(`RPC_RESP_T10_DUS);
      default: resp_exp = `RPC_DUS2CYC(`RPC_RESP_T11_DUS);
    endcase
  endfunction
  function [31:0] idle_exp(input integer c);
    case (c)
      0: idle_exp = `RPC_DUS2CYC(`RPC_IDLE_T00_DUS);
      1: idle_exp = `RPC_DUS2CYC(`RPC_IDLE_T01_DUS);
      2: idle_exp = `RPC_DUS2CYC(`RPC_IDLE_T10_DUS);
      default: idle_exp = `RPC_DUS2CYC(`RPC_IDLE_T11_DUS);
    endcase
  endfunction
  // Strobe stays up until the next task replaces or drops it
  task wr(input [2:0] a, input [7:0] d);
    @(posedge SYS_CLK);
    WR <= 1'b1; RD <= 1'b0; ADDR <= a; WDATA <= d;
  endtask
  task idle(input integer n);
    repeat (n) @(posedge SYS_CLK) begin
      WR <= 1'b0; RD <= 1'b0;
    end
    // Step off the edge so registered outputs have settled
    #1;
  endtask
  task rd(input [2:0] a);
    @(posedge SYS_CLK);
    WR <= 1'b0; RD <= 1'b1; ADDR <= a;
    @(posedge SYS_CLK);
    RD <= 1'b0;
    #1 rv = RDATA;
  endtask
  // Two reads with no gap between the strobes
  task rd2(input [2:0] a);
    @(posedge SYS_CLK);
    WR <= 1'b0; RD <= 1'b1; ADDR <= a;
    @(posedge SYS_CLK);
    #1 rv = RDATA;
    @(posedge SYS_CLK);
    RD <= 1'b0;
    #1 rv2 = RDATA;
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task t_ptr;
    wr(2, 8'h47); wr(3, 8'hFF); idle(2); #1;
    chk("addr", RAM_ADDR, 11'h7FF);
    wr(4, 8'h3C); wr(4, 8'hC3); idle(2);
    rd(2); chk("ptrhi", rv, 8'h40);
    rd(3); chk("ptrlo", rv, 8'h01);
    wr(2, 8'hC7); wr(3, 8'hFF); idle(2);
    rd(4); chk("rdat0", rv, 8'h3C);
    rd(4); chk("rdat1", rv, 8'hC3);
    wr(2, 8'hC0); idle(1); wr(3, 8'h10); rd2(4);
    chk("burst0", rv, 8'h4A);
    chk("burst1", rv2, 8'h4B);
    rd(5); chk("unmap", rv, 8'h00);
    $display("test pointer done");
  endtask
  task t_noauto;
    wr(2, 8'h83); wr(3, 8'h10); idle(2);
    rd(4); chk("fix0", rv, 8'h4A);
    rd(4); chk("fix1", rv, 8'h4A);
    wr(2, 8'h83); wr(4, 8'h11); idle(2);
    rd(4); chk("refuse", rv, 8'h4A);
    #1 chk("fixaddr", RAM_ADDR, 11'h310);
    wr(2, 8'h83); rd(4);
    $display("test fixed pointer done");
  endtask
  task t_ctrl;
    for (i = 0; i < 4; i = i + 1) begin
      SHARED_RDATA <= 8'hA0 + i[7:0];
      wr(6, i[7:0]); rd(7);
      chk("shared", rv, 8'hA0 + i);
      chk("sel", SHARED_REG_SEL, i);
    end
    wr(7, 8'h5A); idle(1);
    chk("shwr", SHARED_WR_STB, 1'b1);
    chk("hwdat", HOST_WDATA, 8'h5A);
    idle(1); chk("shwr0", SHARED_WR_STB, 1'b0);
    wr(1, 8'hFF); wr(6, 8'hC0); idle(2);
    chk("swrst", SOFT_RESET, 1'b1);
    chk("chain", CHAINED_COMMAND_ENABLE, 1'b1);
    rd(6); chk("ctrlkeep", rv, 8'hC0);
    wr(6, 8'h40); idle(2);
    chk("swrel", SOFT_RESET, 1'b0);
    $display("test control done");
  endtask
  task t_line;
    chk("drv_off", LINE_DRIVER_ENABLE_N, 1'b1);
    wr(6, 8'h04); idle(2);
    chk("b_direct", LINE_PULSE_B_N, 1'b0);
    chk("a_off", LINE_PULSE_A_N, 1'b1);
    chk("direct", DIRECT_MEDIA_SIGNALLING, 1'b1);
    wr(6, 8'h20); idle(2);
    chk("drv_on", LINE_DRIVER_ENABLE_N, 1'b0);
    chk("a_on", LINE_PULSE_A_N, 1'b0);
    @(posedge SYS_CLK);
    PULSE_A_REQ <= 1'b0;
    DRIVER_EN_REQ <= 1'b0;
    idle(2);
    chk("a_noreq", LINE_PULSE_A_N, 1'b1);
    chk("drv_nrq", LINE_DRIVER_ENABLE_N, 1'b1);
    @(posedge SYS_CLK);
    PULSE_A_REQ <= 1'b1;
    DRIVER_EN_REQ <= 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      wr(6, i[7:0] << 3); idle(3);
      chk("resp", RESP_TIMEOUT_CYC, resp_exp(i));
      chk("idle", IDLE_TIMEOUT_CYC, idle_exp(i));
      chk("recon", RECON_TIMEOUT_CYC,
        (i == 3) ? recon_short_cyc : recon_long_cyc);
    end
    $display("test line and timeout done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    SYS_CLK = 1'b0;
    forever #2 SYS_CLK = ~SYS_CLK;
  end
  initial begin
    repeat (5000) @(posedge SYS_CLK);
    n_mismatch = n_mismatch + 1;
    complete_run;
  end
  initial begin
    RST_B = 1'b0; WR = 1'b0; RD = 1'b0; ADDR = 3'h0; WDATA = 8'h00;
    SHARED_RDATA = 8'h00; PULSE_A_REQ = 1'b1; PULSE_B_REQ = 1'b1;
    DRIVER_EN_REQ = 1'b1;
    repeat (8) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    rd(6); chk("ctrlrst", rv, 8'h00);
    t_line; t_ptr; t_noauto; t_ctrl;
    complete_run;
  end
endmodule
